// ===== core/phy_base_regs_pkg.sv
// Purpose: Constants for the base register controls of a three-port cable physical layer.
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word.
// Notes: The printed offsets are register indices; the byte address is four times the index.
// How it works
// - Cable power fall sets cable power flag.
// - Cable power flag resets to one; write-one clears.
// - Cable power flag plus watchdog wakes idle link.
// - State time-out sets flag and requests bus reset.
// - Time-out flag resets zero; write-one clears.
// - Time-out flag plus watchdog wakes idle link.
// - Enabled port status change sets port event flag.
// - Resume start sets port event under watchdog.
// - Port event flag resets zero; write-one clears.
// - Arbitration acceleration enable, zero reset, ignored 1394b.
// - Multispeed concatenation enable, zero reset, ignored 1394b.
// - Legacy speed field reports highest capped self-ID speed since bus init.
// - Link-mode bit mirrors link mode select pin.
// - Two-bit bridge field, zero after reset.
// - Three-bit page selector, zero after reset.
// - Four-bit port selector, zero after reset.
// - Unimplemented port reads whole status page zero.
// - Watchdog enable gates resume event and wake.
package phy_base_regs_pkg;
    localparam logic [3:0] IDX_IRQ_FLAGS   = 4'h5;  // Flags and watchdog enable.
    localparam logic [3:0] IDX_FEATURES    = 4'h6;  // Enables, legacy speed, link mode, bridge.
    localparam logic [3:0] IDX_PAGE_PORT   = 4'h7;  // Page and port selection.
    localparam logic [3:0] IDX_PAGE_FIRST  = 4'h8;  // First paged register.
    localparam int         ADDR_WORD_LSB   = 2;
    localparam int         ADDR_IDX_W      = 4;
    // Flag register fields.
    localparam int         BIT_WDOG        = 0;
    localparam int         BIT_PEI         = 1;
    localparam int         BIT_STATE_TIMEOUT_IRQ_FLAG        = 2;
    localparam int         BIT_CABLE_POWER_IRQ_FLAG        = 3;
    // Feature register fields.
    localparam int         BIT_EAA         = 0;
    localparam int         BIT_EMC         = 1;
    localparam int         LSB_LEGACY_SPD  = 2;
    localparam int         BIT_LINK_MODE   = 5;
    localparam int         LSB_BRIDGE      = 6;
    // Page and port register fields.
    localparam int         LSB_PORT_SEL    = 0;
    localparam int         LSB_PAGE_SEL    = 4;
    localparam logic [2:0] SPEED_S400      = 3'h2;
    localparam logic [2:0] PAGE_PORT_STAT  = 3'h0;
    localparam logic       RST_CABLE_POWER_IRQ_FLAG        = 1'b1;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage

// ===== core/phy_base_regs.sv
// Purpose: Base register controls of a cable physical layer, reached over AXI4-Lite.
// Assumes: Event inputs are single-cycle pulses synchronous to CLK.
// Notes: Port status page content comes in on PORT_PAGE_DATA, flattened per port.
`timescale 1ns/100ps
`default_nettype none
module phy_base_regs
    import phy_base_regs_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter int PAGE_REGS = 8
) (
    input  wire logic                          CLK,
    input  wire logic                          RST,
    input  wire logic                          CE,
    input  wire logic [5:0]                    S_AWADDR,
    input  wire logic                          S_AWVALID,
    output logic                               S_AWREADY,
    input  wire logic [31:0]                   S_WDATA,
    input  wire logic [3:0]                    S_WSTRB,
    input  wire logic                          S_WVALID,
    output logic                               S_WREADY,
    output logic [1:0]                         S_BRESP,
    output logic                               S_BVALID,
    input  wire logic                          S_BREADY,
    input  wire logic [5:0]                    S_ARADDR,
    input  wire logic                          S_ARVALID,
    output logic                               S_ARREADY,
    output logic [31:0]                        S_RDATA,
    output logic [1:0]                         S_RRESP,
    output logic                               S_RVALID,
    input  wire logic                          S_RREADY,
    input  wire logic                          CABLE_POWER_SENSE_IN,
    input  wire logic                          STATE_TIMEOUT_EVENT,
    input  wire logic [NUM_PORTS-1:0]          PORT_STATUS_CHANGE,
    input  wire logic [NUM_PORTS-1:0]          PER_PORT_EVENT_ENABLE,
    input  wire logic [NUM_PORTS-1:0]          PORT_RESUME_START,
    input  wire logic                          LINK_ACTIVE,
    input  wire logic                          BETA_MODE,
    input  wire logic                          SELF_ID_LEGACY_VALID,
    input  wire logic [2:0]                    SELF_ID_LEGACY_SPEED,
    input  wire logic                          BUS_INIT_START,
    input  wire logic                          LINK_MODE_SELECT_PIN,
    input  wire logic [NUM_PORTS*PAGE_REGS*8-1:0] PORT_PAGE_DATA,
    output logic                               LINK_ON_NOTIFY_OUT,
    output logic                               BUS_RESET_REQUEST,
    output logic                               ARB_ACCEL_ACTIVE,
    output logic                               MULTISPEED_CONCAT_ACTIVE,
    output logic [1:0]                         BRIDGE_FIELD,
    output logic [2:0]                         PAGE_SELECT,
    output logic [3:0]                         PORT_SELECT
);

    // Control and status state.
    logic       cable_power_irq_flag;
    logic       state_timeout_irq_flag;
    logic       port_event_irq_flag;
    logic       watchdog_wake_enable;
    logic       arb_acceleration_enable;
    logic       multispeed_concat_enable;
    logic [2:0] legacy_path_speed;
    logic [1:0] bridge;
    logic [2:0] page_sel;
    logic [3:0] port_sel;
    logic       cps_prev;
    logic       beta_link_present;

    // Bus slave state.
    logic                  aw_held;
    logic                  w_held;
    logic [ADDR_IDX_W-1:0] aw_idx;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;

    // Caps a self-ID speed code at the legacy ceiling.
    function automatic logic [2:0] cap_speed(input logic [2:0] code);
        cap_speed = (code > SPEED_S400) ? SPEED_S400 : code;
    endfunction

    // Turns a byte address into a register index.
    function automatic logic [ADDR_IDX_W-1:0] word_idx(input logic [5:0] addr);
        word_idx = addr[ADDR_WORD_LSB +: ADDR_IDX_W];
    endfunction

    // Write channel decode: a write happens once address and data are both held.
    wire        wr_fire   = aw_held && w_held && !S_BVALID;
    wire        wr_flags  = wr_fire && (aw_idx == IDX_IRQ_FLAGS) && w_strb[0];
    wire        wr_feat   = wr_fire && (aw_idx == IDX_FEATURES) && w_strb[0];
    wire        wr_pgport = wr_fire && (aw_idx == IDX_PAGE_PORT) && w_strb[0];
    wire        wr_mapped = (aw_idx == IDX_IRQ_FLAGS) || (aw_idx == IDX_FEATURES)
                          || (aw_idx == IDX_PAGE_PORT);

    // Flag events and their write-one clears; the set term is applied last.
    wire cps_fall   = cps_prev && !CABLE_POWER_SENSE_IN;
    wire port_event = |(PORT_STATUS_CHANGE & PER_PORT_EVENT_ENABLE)
                    || (watchdog_wake_enable && |PORT_RESUME_START);
    wire clr_cable_power_irq_flag   = wr_flags && w_data[BIT_CABLE_POWER_IRQ_FLAG];
    wire clr_state_timeout_irq_flag   = wr_flags && w_data[BIT_STATE_TIMEOUT_IRQ_FLAG];
    wire clr_pei    = wr_flags && w_data[BIT_PEI];
    wire next_cable_power_irq_flag  = cps_fall || (cable_power_irq_flag && !clr_cable_power_irq_flag);
    wire next_state_timeout_irq_flag  = STATE_TIMEOUT_EVENT || (state_timeout_irq_flag && !clr_state_timeout_irq_flag);
    wire next_pei   = port_event || (port_event_irq_flag && !clr_pei);

    // Wake request while the link is idle and a serviced flag stands.
    wire next_link_on = watchdog_wake_enable && !LINK_ACTIVE
                      && (cable_power_irq_flag || state_timeout_irq_flag);

    // Paged read: port status page of the selected port, zero if not implemented.
    wire        port_ok   = (port_sel < 4'(NUM_PORTS));
    wire [ADDR_IDX_W-1:0] rd_idx = word_idx(S_ARADDR);
    wire        rd_paged  = (rd_idx >= IDX_PAGE_FIRST);
    wire [2:0]  page_off  = 3'(rd_idx - IDX_PAGE_FIRST);
    wire [7:0]  page_byte = (port_ok && page_sel == PAGE_PORT_STAT && port_sel < 4'(NUM_PORTS))
                          ? PORT_PAGE_DATA[(int'(port_sel) * PAGE_REGS + int'(page_off)) * 8 +: 8]
                          : 8'h00;
    wire [7:0]  flags_rd  = {4'h0, cable_power_irq_flag, state_timeout_irq_flag,
                             port_event_irq_flag, watchdog_wake_enable};
    wire [7:0]  feat_rd   = {bridge, beta_link_present, legacy_path_speed,
                             multispeed_concat_enable, arb_acceleration_enable};
    wire [7:0]  pgport_rd = {1'b0, page_sel, port_sel};
    wire        rd_mapped = rd_paged || (rd_idx == IDX_IRQ_FLAGS)
                          || (rd_idx == IDX_FEATURES) || (rd_idx == IDX_PAGE_PORT);
    wire [7:0]  rd_byte   = rd_paged                    ? page_byte :
                            (rd_idx == IDX_IRQ_FLAGS)   ? flags_rd  :
                            (rd_idx == IDX_FEATURES)    ? feat_rd   :
                            (rd_idx == IDX_PAGE_PORT)   ? pgport_rd : 8'h00;

    // Interrupt flags, edge history and the wake output.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cable_power_irq_flag   <= RST_CABLE_POWER_IRQ_FLAG;
            state_timeout_irq_flag <= 1'b0;
            port_event_irq_flag    <= 1'b0;
            cps_prev               <= 1'b0;
            LINK_ON_NOTIFY_OUT     <= 1'b0;
            BUS_RESET_REQUEST      <= 1'b0;
        end else if (CE) begin
            cable_power_irq_flag   <= next_cable_power_irq_flag;
            state_timeout_irq_flag <= next_state_timeout_irq_flag;
            port_event_irq_flag    <= next_pei;
            cps_prev               <= CABLE_POWER_SENSE_IN;
            LINK_ON_NOTIFY_OUT     <= next_link_on;
            BUS_RESET_REQUEST      <= STATE_TIMEOUT_EVENT;
        end
    end

    // Software-written controls; none is touched by bus reset.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            watchdog_wake_enable     <= 1'b0;
            arb_acceleration_enable  <= 1'b0;
            multispeed_concat_enable <= 1'b0;
            bridge                   <= 2'h0;
            page_sel                 <= 3'h0;
            port_sel                 <= 4'h0;
        end else if (CE) begin
            if (wr_flags) begin
                watchdog_wake_enable <= w_data[BIT_WDOG];
            end
            if (wr_feat) begin
                arb_acceleration_enable  <= w_data[BIT_EAA];
                multispeed_concat_enable <= w_data[BIT_EMC];
                bridge                   <= w_data[LSB_BRIDGE +: 2];
            end
            if (wr_pgport) begin
                port_sel <= w_data[LSB_PORT_SEL +: 4];
                page_sel <= w_data[LSB_PAGE_SEL +: 3];
            end
        end
    end

    // Observed status: legacy speed from self-ID, link mode pin mirror.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            legacy_path_speed <= 3'h0;
            beta_link_present <= 1'b0;
        end else if (CE) begin
            beta_link_present <= LINK_MODE_SELECT_PIN;
            if (BUS_INIT_START) begin
                legacy_path_speed <= 3'h0;
            end else if (SELF_ID_LEGACY_VALID
                         && cap_speed(SELF_ID_LEGACY_SPEED) > legacy_path_speed) begin
                legacy_path_speed <= cap_speed(SELF_ID_LEGACY_SPEED);
            end
        end
    end

    // Effective feature enables and field copies driven out of flip-flops.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ARB_ACCEL_ACTIVE         <= 1'b0;
            MULTISPEED_CONCAT_ACTIVE <= 1'b0;
            BRIDGE_FIELD             <= 2'h0;
            PAGE_SELECT              <= 3'h0;
            PORT_SELECT              <= 4'h0;
        end else if (CE) begin
            ARB_ACCEL_ACTIVE         <= arb_acceleration_enable && !BETA_MODE;
            MULTISPEED_CONCAT_ACTIVE <= multispeed_concat_enable && !BETA_MODE;
            BRIDGE_FIELD             <= bridge;
            PAGE_SELECT              <= page_sel;
            PORT_SELECT              <= port_sel;
        end
    end

    // Write channels: address and data are taken in either order, then answered.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_idx    <= '0;
            w_data    <= 32'h0;
            w_strb    <= 4'h0;
            S_AWREADY <= 1'b0;
            S_WREADY  <= 1'b0;
            S_BVALID  <= 1'b0;
            S_BRESP   <= RESP_OKAY;
        end else if (CE) begin
            S_AWREADY <= 1'b0;
            S_WREADY  <= 1'b0;
            if (S_AWVALID && !aw_held && !S_AWREADY) begin
                S_AWREADY <= 1'b1;
                aw_held   <= 1'b1;
                aw_idx    <= word_idx(S_AWADDR);
            end
            if (S_WVALID && !w_held && !S_WREADY) begin
                S_WREADY <= 1'b1;
                w_held   <= 1'b1;
                w_data   <= S_WDATA;
                w_strb   <= S_WSTRB;
            end
            if (wr_fire) begin
                S_BVALID <= 1'b1;
                S_BRESP  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (S_BVALID && S_BREADY) begin
                S_BVALID <= 1'b0;
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, data captured as the address is taken.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_ARREADY <= 1'b0;
            S_RVALID  <= 1'b0;
            S_RDATA   <= 32'h0;
            S_RRESP   <= RESP_OKAY;
        end else if (CE) begin
            S_ARREADY <= 1'b0;
            if (S_ARVALID && !S_RVALID && !S_ARREADY) begin
                S_ARREADY <= 1'b1;
                S_RVALID  <= 1'b1;
                S_RDATA   <= {24'h0, rd_byte};
                S_RRESP   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (S_RVALID && S_RREADY) begin
                S_RVALID <= 1'b0;
            end
        end
    end

endmodule // phy_base_regs
`default_nettype wire

// ===== tb/phy_base_regs_properties.sv
// Purpose: Timing checks on the ports of the base register block.
// Assumes: CE is held high while the checks run.
// Notes: Attached to every instance of the block by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module phy_base_regs_properties (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        S_AWREADY,
    input wire logic        S_WREADY,
    input wire logic        S_BVALID,
    input wire logic        S_BREADY,
    input wire logic [1:0]  S_BRESP,
    input wire logic        S_ARREADY,
    input wire logic        S_RVALID,
    input wire logic        S_RREADY,
    input wire logic [31:0] S_RDATA,
    input wire logic        STATE_TIMEOUT_EVENT,
    input wire logic        LINK_ACTIVE,
    input wire logic        BETA_MODE,
    input wire logic        LINK_ON_NOTIFY_OUT,
    input wire logic        BUS_RESET_REQUEST,
    input wire logic        ARB_ACCEL_ACTIVE,
    input wire logic        MULTISPEED_CONCAT_ACTIVE,
    input wire logic [1:0]  BRIDGE_FIELD,
    input wire logic [2:0]  PAGE_SELECT,
    input wire logic [3:0]  PORT_SELECT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // A write taken on both channels is answered in the following cycle.
    sequence wr_taken; S_AWREADY && S_WREADY; endsequence
    sequence wr_answer; ##1 S_BVALID; endsequence
    a_write_answer: assert property (wr_taken |-> wr_answer)
        else $error("write not answered");
    a_read_answer: assert property (S_ARREADY |-> S_RVALID)
        else $error("read not answered");
    // A held response must keep its code until the master takes it.
    a_bresp_hold: assert property (S_BVALID && !S_BREADY |=>
        S_BVALID && $stable(S_BRESP))
        else $error("write response dropped");
    a_rdata_hold: assert property (S_RVALID && !S_RREADY |=>
        S_RVALID && $stable(S_RDATA))
        else $error("read data dropped");
    a_timeout_bus_reset: assert property (STATE_TIMEOUT_EVENT |=> BUS_RESET_REQUEST)
        else $error("time-out gave no bus reset");
    a_accel_beta_off: assert property (BETA_MODE |=> !ARB_ACCEL_ACTIVE)
        else $error("acceleration active in beta mode");
    a_concat_beta_off: assert property (BETA_MODE |=> !MULTISPEED_CONCAT_ACTIVE)
        else $error("concatenation active in beta mode");
    a_notify_link_idle: assert property (LINK_ACTIVE |=> !LINK_ON_NOTIFY_OUT)
        else $error("notify raised for active link");
    // Selector outputs only move in the cycle after a write lands.
    a_select_stable: assert property (!$rose(S_BVALID) |=>
        $stable({BRIDGE_FIELD, PAGE_SELECT, PORT_SELECT}))
        else $error("selector moved without a write");
endmodule // phy_base_regs_properties
bind phy_base_regs phy_base_regs_properties chk_i (.*);
`default_nettype wire

// ===== tb/link_partner.sv
// Purpose: Behavioural link-layer controller that sleeps and wakes on notify.
// Assumes: One clock shared with the block.
// Notes: WAKE_CYCLES sets how slowly it answers a notify.
`timescale 1ns/100ps
`default_nettype none
module link_partner #(
    parameter int WAKE_CYCLES = 4,
    parameter bit COMPLIANT   = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic go_idle,
    input  wire logic notify,
    output logic      active,
    output logic      compliant
);
    int cnt;
    // Sleeps on request and wakes a few cycles after being notified.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b1;
            cnt    <= 0;
        end else if (go_idle) begin
            active <= 1'b0;
            cnt    <= 0;
        end else if (!active && notify) begin
            cnt    <= cnt + 1;
            active <= (cnt == WAKE_CYCLES - 1);
        end
    end
    // Software may only turn on acceleration when this is high.
    assign compliant = COMPLIANT;
endmodule // link_partner
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the base register block.
// Assumes: Register access over AXI4-Lite, one transfer at a time.
// Notes: Signals carry the port names so the block is wired by name.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import phy_base_regs_pkg::*;
    logic CLK = 0, RST = 1, CE = 1, S_AWVALID = 0, S_WVALID = 0, S_BREADY = 0;
    logic S_ARVALID = 0, S_RREADY = 0, CABLE_POWER_SENSE_IN = 1, STATE_TIMEOUT_EVENT = 0;
    logic BETA_MODE = 0, SELF_ID_LEGACY_VALID = 0, BUS_INIT_START = 0, LINK_MODE_SELECT_PIN = 1;
    logic [5:0] S_AWADDR = 0, S_ARADDR = 0;
    logic [31:0] S_WDATA = 0, S_RDATA;
    logic [3:0] S_WSTRB = 4'hF, PORT_SELECT;
    logic [2:0] PORT_STATUS_CHANGE = 0, PER_PORT_EVENT_ENABLE = 0, PORT_RESUME_START = 0;
    logic [2:0] SELF_ID_LEGACY_SPEED = 0, PAGE_SELECT;
    logic [191:0] PORT_PAGE_DATA;
    logic [1:0] S_BRESP, S_RRESP, BRIDGE_FIELD;
    logic S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, LINK_ACTIVE, LINK_ON_NOTIFY_OUT;
    logic BUS_RESET_REQUEST, ARB_ACCEL_ACTIVE, MULTISPEED_CONCAT_ACTIVE, go_idle = 0, compliant;
    logic [31:0] d;
    logic [1:0] r;
    int errors = 0, total_checks = 0;
    phy_base_regs dut (.*);
    link_partner #(.WAKE_CYCLES(4), .COMPLIANT(1'b1)) lp (.clk(CLK), .rst(RST),
        .go_idle(go_idle), .notify(LINK_ON_NOTIFY_OUT), .active(LINK_ACTIVE),
        .compliant(compliant));
    // Clock of 8 ns period.
    always #4 CLK = ~CLK;
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Write; a nonzero lag lets the response wait that many cycles before it is taken.
    task automatic wr(input logic [5:0] a, input logic [31:0] v, input int lag = 0);
        @(posedge CLK);
        S_AWADDR <= a;
        S_WDATA <= v;
        S_AWVALID <= 1'b1;
        S_WVALID <= 1'b1;
        S_BREADY <= (lag == 0);
        do begin
            @(posedge CLK);
            if (S_AWREADY) S_AWVALID <= 1'b0;
            if (S_WREADY) S_WVALID <= 1'b0;
        end while (!S_BVALID);
        if (lag > 0) begin
            repeat (lag) @(posedge CLK);
            S_BREADY <= 1'b1;
            @(posedge CLK);
        end
        r = S_BRESP;
        S_BREADY <= 1'b0;
    endtask
    // Read; a nonzero lag lets the data wait that many cycles before it is taken.
    task automatic rd(input logic [5:0] a, input int lag = 0);
        @(posedge CLK);
        S_ARADDR <= a;
        S_ARVALID <= 1'b1;
        S_RREADY <= (lag == 0);
        do begin
            @(posedge CLK);
            if (S_ARREADY) S_ARVALID <= 1'b0;
        end while (!S_RVALID);
        if (lag > 0) begin
            repeat (lag) @(posedge CLK);
            S_RREADY <= 1'b1;
            @(posedge CLK);
        end
        d = S_RDATA;
        r = S_RRESP;
        S_RREADY <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [31:0] exp, input string n);
        rd(a);
        chk(n, d, exp);
    endtask
    // One-cycle event: 0 time-out, 1 status change, 2 resume, 3 self-ID, 4 init, 5 power fall.
    task automatic pulse(input int k, input logic [2:0] v);
        @(posedge CLK);
        case (k)
            0: STATE_TIMEOUT_EVENT <= 1'b1;
            1: PORT_STATUS_CHANGE <= v;
            2: PORT_RESUME_START <= v;
            3: SELF_ID_LEGACY_VALID <= 1'b1;
            4: BUS_INIT_START <= 1'b1;
            default: CABLE_POWER_SENSE_IN <= 1'b0;
        endcase
        SELF_ID_LEGACY_SPEED <= v;
        @(posedge CLK);
        {STATE_TIMEOUT_EVENT, PORT_STATUS_CHANGE, PORT_RESUME_START} <= '0;
        {SELF_ID_LEGACY_VALID, BUS_INIT_START, CABLE_POWER_SENSE_IN} <= 3'h1;
    endtask
    task automatic t_reset;
        rc(6'h14, 32'(RST_CABLE_POWER_IRQ_FLAG) << BIT_CABLE_POWER_IRQ_FLAG, "flags");
        rc(6'h18, 32'h20, "features");
        rc(6'h1C, 32'h0, "select");
    endtask
    task automatic t_flags;
        wr(6'h14, 32'h0);
        chk("write resp", r, RESP_OKAY);
        rc(6'h14, 32'h8, "flags zero write");
        wr(6'h14, 32'h8);
        rc(6'h14, 32'h0, "power flag clear");
        pulse(5, 3'h0);
        rc(6'h14, 32'h8, "power fall");
        wr(6'h14, 32'h8);
        pulse(0, 3'h0);
        #1 chk("bus reset", BUS_RESET_REQUEST, 1'b1);
        rc(6'h14, 32'h4, "time-out flag");
        wr(6'h14, 32'h4);
        rc(6'h14, 32'h0, "time-out clear");
        // The time-out lands in the very cycle the clearing write does.
        fork
            wr(6'h14, 32'h4);
            begin
                repeat (2) @(posedge CLK);
                STATE_TIMEOUT_EVENT <= 1'b1;
                @(posedge CLK);
                STATE_TIMEOUT_EVENT <= 1'b0;
            end
        join
        rc(6'h14, 32'h4, "set beats clear");
        wr(6'h14, 32'h4);
        pulse(1, 3'h7);
        rc(6'h14, 32'h0, "masked change");
        PER_PORT_EVENT_ENABLE <= 3'h2;
        pulse(1, 3'h2);
        rc(6'h14, 32'h2, "port event");
        wr(6'h14, 32'h2);
        pulse(2, 3'h4);
        rc(6'h14, 32'h0, "resume no watchdog");
        wr(6'h14, 32'h1);
        pulse(2, 3'h4);
        rc(6'h14, 32'h3, "resume event");
        wr(6'h14, 32'h2);
        rc(6'h14, 32'h0, "port event clear");
        // An event while the clock enable is low is not seen.
        CE <= 1'b0;
        pulse(1, 3'h2);
        CE <= 1'b1;
        rc(6'h14, 32'h0, "frozen event");
    endtask
    task automatic t_wake;
        int n;
        wr(6'h14, 32'h1);
        for (int i = 0; i < 2; i++) begin
            n = 0;
            @(posedge CLK) go_idle <= 1'b1;
            @(posedge CLK) go_idle <= 1'b0;
            repeat (3) @(posedge CLK);
            chk("quiet idle", LINK_ON_NOTIFY_OUT, 1'b0);
            pulse(i == 0 ? 5 : 0, 3'h0);
            while (!LINK_ON_NOTIFY_OUT && n < 10) @(posedge CLK) n++;
            chk("notify", LINK_ON_NOTIFY_OUT, 1'b1);
            while (LINK_ON_NOTIFY_OUT && n < 30) @(posedge CLK) n++;
            chk("woken", LINK_ACTIVE, 1'b1);
            wr(6'h14, 32'hD);
        end
        wr(6'h14, 32'h0);
    endtask
    task automatic t_features;
        if (compliant) wr(6'h18, 32'hC3);
        rc(6'h18, 32'hE3, "features set");
        chk("outputs", {ARB_ACCEL_ACTIVE, MULTISPEED_CONCAT_ACTIVE, BRIDGE_FIELD}, 4'hF);
        @(posedge CLK) BETA_MODE <= 1'b1;
        LINK_MODE_SELECT_PIN <= 1'b0;
        rc(6'h18, 32'hC3, "beta hold");
        chk("beta off", {ARB_ACCEL_ACTIVE, MULTISPEED_CONCAT_ACTIVE}, 2'h0);
        BETA_MODE <= 1'b0;
        pulse(4, 3'h0);
        pulse(3, 3'h1);
        rc(6'h18, 32'hC7, "legacy speed");
        pulse(3, 3'h5);
        pulse(3, 3'h1);
        rc(6'h18, 32'hC3 | (32'(SPEED_S400) << LSB_LEGACY_SPD), "speed cap");
        // A new bus initialisation forgets the legacy speed; the data waits for a slow master.
        pulse(4, 3'h0);
        rd(6'h18, 2);
        chk("legacy cleared", d, 32'hC3);
    endtask
    task automatic t_pages;
        for (int p = 0; p < 4; p++) begin
            wr(6'h1C, 32'(p));
            rc(6'h24, p < 3 ? 32'(p * 16 + 2) : 32'h0, "port page");
            chk("port select", PORT_SELECT, 4'(p));
        end
        wr(6'h1C, 32'h11);
        rc(6'h24, 32'h0, "other page");
        chk("page select", PAGE_SELECT, 3'h1);
        rc(6'h00, 32'h0, "unmapped");
        chk("unmapped resp", r, RESP_SLVERR);
        wr(6'h00, 32'hFF, 2);
        chk("unmapped write", r, RESP_SLVERR);
    endtask
    // Port page bytes hold port times 16 plus register plus one.
    initial begin
        PORT_PAGE_DATA = '0;
        for (int i = 0; i < 24; i++) PORT_PAGE_DATA[i*8 +: 8] = 8'((i / 8) * 16 + i % 8 + 1);
    end
    // Main sequence after a five-cycle reset.
    initial begin
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        t_flags();
        t_wake();
        t_features();
        t_pages();
        complete_run();
    end
    // Cuts a hang short well beyond the expected run.
    initial begin
        #50000;
        errors++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
